// ---- src/gis_pkg.sv ----
// constants for the global interrupt, status and pin block
//
// Overview of operation
// - two-bit pin select: input, status, low, high
// - status pins map port1 A/B, port2 A/B, port3 A/B, port4 A/B
// - pin four select only when reference input off
// - pin two select only when reference output off
// - port summary set while port irq pending
// - enabled port summary asserts interrupt low
// - global summary is any enabled latched bit
// - enabled global summary asserts interrupt low
// - enables mask at zero, reset to zero
// - live unlock high when any pll unlocked
// - live update done ANDs globally controlled ports
// - latch reference activity on pin four when selected
// - latch adapter reference clock activity
// - latch one-second tick, may raise summary
// - latch rising unlock, may raise summary
// - latch rising update done, may raise summary
// - readback returns eight pin levels, pin1 bit0
// - latched bits clear on write or read mode
// - interrupt drives low, idle floats or drives high
package gis_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [9:0] OFF_CTRL = 10'h000;
  localparam logic [9:0] OFF_REF_CTRL = 10'h004;
  localparam logic [9:0] OFF_PIN_FUNC = 10'h00a;
  localparam logic [9:0] OFF_IRQ_SUM = 10'h010;
  localparam logic [9:0] OFF_IRQ_SUM_EN = 10'h012;
  localparam logic [9:0] OFF_LIVE = 10'h014;
  localparam logic [9:0] OFF_LATCHED = 10'h016;
  localparam logic [9:0] OFF_LATCHED_EN = 10'h018;
  localparam logic [9:0] OFF_PIN_READ = 10'h01c;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_IRQ_IDLE_DRIVE = 14;
  localparam int BIT_UPDATE_REQ = 3;
  localparam int BIT_CLEAR_ON_READ = 2;
  localparam int BIT_REF_OUT_SEL = 9;
  localparam int BIT_REF_IN_SEL = 8;
  localparam int BIT_PORT_SUM_LO = 4;
  localparam int BIT_GLOBAL_SUM = 0;
  localparam int BIT_UNLOCK_LIVE = 1;
  localparam int BIT_UPDATE_LIVE = 0;
  localparam int BIT_REF8K_ACT = 4;
  localparam int BIT_ADAPTER_ACT = 3;
  localparam int BIT_ONE_SEC = 2;
  localparam int BIT_UNLOCK_LAT = 1;
  localparam int BIT_UPDATE_LAT = 0;

  // ----------------------------------------
  // reset values and pin select codes
  // ----------------------------------------
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [4:0] RST_LATCHED = 5'h00;
  localparam logic [1:0] SEL_INPUT = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_LOW = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int ONE_SEC_NS = 1000000000;
  localparam int ONE_SEC_CYCLES = ONE_SEC_NS / CLK_PERIOD_NS;
  localparam int ACT_WINDOW_NS = 250000;
  localparam int ACT_WINDOW_CYCLES =
    (ACT_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_PORTS_MAX = 4;
  localparam int NUM_PLLS = 3;

endpackage : gis_pkg

// ---- src/gis_sync.sv ----
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module gis_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level
);

  // ----------------------------------------
  // per bit chain
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      // first stage feeds only the second
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          level[i] <= 1'b0;
        end else begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            level[i] <= s3_q; // change once stages agree
          end
        end
      end
    end
  endgenerate

endmodule : gis_sync

// ---- src/gis_activity.sv ----
// edge activity monitor over a cycle window
`timescale 1ns/100ps
module gis_activity #(
  parameter int WINDOW = 12500
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic level,
  output logic active
);

  logic prev_q;
  logic [31:0] idle_q;

  // count cycles since the last edge
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
      idle_q <= 32'h0;
      active <= 1'b0;
    end else begin
      prev_q <= level;
      if (!enable) begin
        idle_q <= 32'h0;
        active <= 1'b0;
      end else if (level != prev_q) begin
        idle_q <= 32'h0;
        active <= 1'b1;
      end else if (idle_q >= 32'(WINDOW - 1)) begin
        active <= 1'b0; // no edge inside window
      end else begin
        idle_q <= idle_q + 32'h1;
      end
    end
  end

endmodule : gis_activity

// ---- src/gis_top.sv ----
// global interrupt, status and general-purpose pin block
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module gis_top #(
  parameter int num_ports = 4,
  parameter int one_sec_cycles = gis_pkg::ONE_SEC_CYCLES,
  parameter int act_window = gis_pkg::ACT_WINDOW_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire logic [3:0] port_irq_pending,
  input wire logic [3:0] port_status_a,
  input wire logic [3:0] port_status_b,
  input wire logic [3:0] port_update_done,
  input wire logic [3:0] port_update_source_sel,
  output logic global_update_request,
  input wire logic [2:0] adapter_pll_locked,
  input wire logic adapter_clock_pin_a,
  input wire logic ref8k_out,
  output logic ref8k_in,
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe,
  output logic irq_n_out,
  output logic irq_n_oe
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [3:0] port_mask;
  logic wr_ctrl;
  logic wr_ref_ctrl;
  logic wr_pin_func;
  logic wr_sum_en;
  logic wr_latched;
  logic wr_latched_en;
  logic rd_latched;

  logic irq_pin_idle_drive_q;
  logic global_update_request_q;
  logic latched_clear_on_read_q;
  logic ref8k_output_select_q;
  logic ref8k_input_select_q;
  logic [15:0] pin_function_q;
  logic [3:0] port_irq_summary_en_q;
  logic global_summary_en_q;
  logic one_second_irq_en_q;
  logic adapter_unlock_irq_en_q;
  logic update_done_irq_en_q;

  logic [4:0] latched_q;
  logic [4:0] latched_d;
  logic [4:0] set_ev;
  logic [4:0] clr_ev;

  logic [2:0] pll_locked_s;
  logic [7:0] gpio_in_s;
  logic adapter_clk_s;
  logic ref8k_active;
  logic adapter_ref_active;

  logic adapter_unlock_live;
  logic adapter_unlock_prev_q;
  logic global_update_done_live;
  logic update_done_prev_q;
  logic [31:0] sec_cnt_q;
  logic one_sec_tick;

  logic [3:0] port_irq_summary;
  logic global_summary_flag;
  logic irq_active;

  logic [7:0] pin_drive;
  logic [7:0] pin_oe;
  logic [7:0] pin_level;
  logic [15:0] rd_mux;
  logic [15:0] rdata_q;

  // ----------------------------------------
  // port presence
  // ----------------------------------------
  // absent ports tie their inputs inactive
  genvar p;
  generate
    for (p = 0; p < gis_pkg::NUM_PORTS_MAX; p++) begin : g_port
      assign port_mask[p] = (p < num_ports);
    end
  endgenerate

  // ----------------------------------------
  // register strobes
  // ----------------------------------------
  // one decode per writable register
  assign wr_ctrl = wr_en && (addr == gis_pkg::OFF_CTRL);
  assign wr_ref_ctrl = wr_en && (addr == gis_pkg::OFF_REF_CTRL);
  assign wr_pin_func = wr_en && (addr == gis_pkg::OFF_PIN_FUNC);
  assign wr_sum_en = wr_en && (addr == gis_pkg::OFF_IRQ_SUM_EN);
  assign wr_latched = wr_en && (addr == gis_pkg::OFF_LATCHED);
  assign wr_latched_en = wr_en && (addr == gis_pkg::OFF_LATCHED_EN);
  assign rd_latched = rd_en && (addr == gis_pkg::OFF_LATCHED);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // global control: idle drive, update request, clear mode
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_pin_idle_drive_q <= 1'b0;
      global_update_request_q <= 1'b0;
      latched_clear_on_read_q <= 1'b0;
    end else if (wr_ctrl) begin
      irq_pin_idle_drive_q <= wdata[gis_pkg::BIT_IRQ_IDLE_DRIVE];
      global_update_request_q <= wdata[gis_pkg::BIT_UPDATE_REQ];
      latched_clear_on_read_q <= wdata[gis_pkg::BIT_CLEAR_ON_READ];
    end
  end

  assign global_update_request = global_update_request_q;

  // reference pin steering
  always_ff @(posedge clk) begin
    if (rst) begin
      ref8k_output_select_q <= 1'b0;
      ref8k_input_select_q <= 1'b0;
    end else if (wr_ref_ctrl) begin
      ref8k_output_select_q <= wdata[gis_pkg::BIT_REF_OUT_SEL];
      ref8k_input_select_q <= wdata[gis_pkg::BIT_REF_IN_SEL];
    end
  end

  // pin function selects, two bits per pin
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_function_q <= gis_pkg::RST_REG;
    end else if (wr_pin_func) begin
      pin_function_q <= wdata;
    end
  end

  // summary enables, all clear after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      port_irq_summary_en_q <= 4'h0;
      global_summary_en_q <= 1'b0;
    end else if (wr_sum_en) begin
      port_irq_summary_en_q <= wdata[gis_pkg::BIT_PORT_SUM_LO +: 4];
      global_summary_en_q <= wdata[gis_pkg::BIT_GLOBAL_SUM];
    end
  end

  // latched status enables, all clear after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      one_second_irq_en_q <= 1'b0;
      adapter_unlock_irq_en_q <= 1'b0;
      update_done_irq_en_q <= 1'b0;
    end else if (wr_latched_en) begin
      one_second_irq_en_q <= wdata[gis_pkg::BIT_ONE_SEC];
      adapter_unlock_irq_en_q <= wdata[gis_pkg::BIT_UNLOCK_LAT];
      update_done_irq_en_q <= wdata[gis_pkg::BIT_UPDATE_LAT];
    end
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  gis_sync #(
    .W(gis_pkg::NUM_PLLS)
  ) u_sync_pll (
    .clk(clk),
    .rst(rst),
    .async_in(adapter_pll_locked),
    .level(pll_locked_s)
  );

  gis_sync #(
    .W(8)
  ) u_sync_gpio (
    .clk(clk),
    .rst(rst),
    .async_in(gpio_in),
    .level(gpio_in_s)
  );

  gis_sync #(
    .W(1)
  ) u_sync_adapter_clock_pin_a (
    .clk(clk),
    .rst(rst),
    .async_in(adapter_clock_pin_a),
    .level(adapter_clk_s)
  );

  // ----------------------------------------
  // activity monitors
  // ----------------------------------------
  // reference on pin four, watched only when selected
  gis_activity #(
    .WINDOW(act_window)
  ) u_act_ref8k (
    .clk(clk),
    .rst(rst),
    .enable(ref8k_input_select_q),
    .level(gpio_in_s[3]),
    .active(ref8k_active)
  );

  // adapter reference on the first adapter clock pin
  gis_activity #(
    .WINDOW(act_window)
  ) u_act_adapter (
    .clk(clk),
    .rst(rst),
    .enable(1'b1),
    .level(adapter_clk_s),
    .active(adapter_ref_active)
  );

  // reference level handed to ports, low when not selected
  always_ff @(posedge clk) begin
    if (rst) begin
      ref8k_in <= 1'b0;
    end else begin
      ref8k_in <= ref8k_input_select_q & gpio_in_s[3];
    end
  end

  // ----------------------------------------
  // live status
  // ----------------------------------------
  // unlocked if any adapter pll lost lock
  assign adapter_unlock_live = ~(&pll_locked_s);

  // all globally controlled ports done, request held
  assign global_update_done_live = global_update_request_q &
    (&(port_update_done | ~(port_update_source_sel & port_mask)));

  // ----------------------------------------
  // one-second timer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_cnt_q <= 32'h0;
    end else if (one_sec_tick) begin
      sec_cnt_q <= 32'h0;
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h1;
    end
  end

  assign one_sec_tick = (sec_cnt_q == 32'(one_sec_cycles - 1));

  // ----------------------------------------
  // edge history for latched events
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      adapter_unlock_prev_q <= 1'b1; // no false unlock edge after reset
      update_done_prev_q <= 1'b0;
    end else begin
      adapter_unlock_prev_q <= adapter_unlock_live;
      update_done_prev_q <= global_update_done_live;
    end
  end

  // ----------------------------------------
  // latched status
  // ----------------------------------------
  // set sources for each latched bit
  always_comb begin
    set_ev = 5'h00;
    set_ev[gis_pkg::BIT_REF8K_ACT] = ref8k_active;
    set_ev[gis_pkg::BIT_ADAPTER_ACT] = adapter_ref_active;
    set_ev[gis_pkg::BIT_ONE_SEC] = one_sec_tick;
    set_ev[gis_pkg::BIT_UNLOCK_LAT] =
      adapter_unlock_live & ~adapter_unlock_prev_q;
    set_ev[gis_pkg::BIT_UPDATE_LAT] =
      global_update_done_live & ~update_done_prev_q;
  end

  // write one to clear, or read clears what was read
  always_comb begin
    clr_ev = 5'h00;
    if (latched_clear_on_read_q) begin
      if (rd_latched) begin
        clr_ev = latched_q;
      end
    end else if (wr_latched) begin
      clr_ev = wdata[4:0];
    end
  end

  // a set in the clearing cycle survives
  assign latched_d = (latched_q & ~clr_ev) | set_ev;

  always_ff @(posedge clk) begin
    if (rst) begin
      latched_q <= gis_pkg::RST_LATCHED;
    end else begin
      latched_q <= latched_d;
    end
  end

  // ----------------------------------------
  // summaries and interrupt
  // ----------------------------------------
  assign port_irq_summary = port_irq_pending & port_mask;

  // only the three event bits have enables
  assign global_summary_flag =
    (latched_q[gis_pkg::BIT_ONE_SEC] & one_second_irq_en_q) |
    (latched_q[gis_pkg::BIT_UNLOCK_LAT] & adapter_unlock_irq_en_q) |
    (latched_q[gis_pkg::BIT_UPDATE_LAT] & update_done_irq_en_q);

  assign irq_active =
    (|(port_irq_summary & port_irq_summary_en_q)) |
    (global_summary_flag & global_summary_en_q);

  // low while active, idle per pin mode
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_n_out <= 1'b1;
      irq_n_oe <= 1'b0;
    end else if (irq_active) begin
      irq_n_out <= 1'b0;
      irq_n_oe <= 1'b1;
    end else begin
      irq_n_out <= 1'b1;
      irq_n_oe <= irq_pin_idle_drive_q;
    end
  end

  // ----------------------------------------
  // general-purpose pins
  // ----------------------------------------
  // pin k shows port k/2 status, A on even index
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic [1:0] sel;
      logic status;
      assign sel = pin_function_q[2*g +: 2];
      if (g % 2 == 0) begin : g_a
        assign status = port_status_a[g/2] & port_mask[g/2];
      end else begin : g_b
        assign status = port_status_b[g/2] & port_mask[g/2];
      end
      always_comb begin
        pin_drive[g] = 1'b0;
        pin_oe[g] = 1'b0;
        if (g == 3 && ref8k_input_select_q) begin
          pin_oe[g] = 1'b0;
        end else if (g == 1 && ref8k_output_select_q) begin
          pin_drive[g] = ref8k_out;
          pin_oe[g] = 1'b1;
        end else begin
          case (sel)
            gis_pkg::SEL_STATUS: begin
              pin_drive[g] = status;
              pin_oe[g] = 1'b1;
            end
            gis_pkg::SEL_LOW: begin
              pin_drive[g] = 1'b0;
              pin_oe[g] = 1'b1;
            end
            gis_pkg::SEL_HIGH: begin
              pin_drive[g] = 1'b1;
              pin_oe[g] = 1'b1;
            end
            default: begin
              pin_oe[g] = 1'b0;
            end
          endcase
        end
      end
      // level seen on the pin, driven or sampled
      assign pin_level[g] = gpio_oe[g] ? gpio_out[g] : gpio_in_s[g];
    end
  endgenerate

  // registered pin drivers
  always_ff @(posedge clk) begin
    if (rst) begin
      gpio_out <= 8'h00;
      gpio_oe <= 8'h00;
    end else begin
      gpio_out <= pin_drive;
      gpio_oe <= pin_oe;
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  always_comb begin
    rd_mux = 16'h0000;
    case (addr)
      gis_pkg::OFF_CTRL: begin
        rd_mux[gis_pkg::BIT_IRQ_IDLE_DRIVE] = irq_pin_idle_drive_q;
        rd_mux[gis_pkg::BIT_UPDATE_REQ] = global_update_request_q;
        rd_mux[gis_pkg::BIT_CLEAR_ON_READ] = latched_clear_on_read_q;
      end
      gis_pkg::OFF_REF_CTRL: begin
        rd_mux[gis_pkg::BIT_REF_OUT_SEL] = ref8k_output_select_q;
        rd_mux[gis_pkg::BIT_REF_IN_SEL] = ref8k_input_select_q;
      end
      gis_pkg::OFF_PIN_FUNC: begin
        rd_mux = pin_function_q;
      end
      gis_pkg::OFF_IRQ_SUM: begin
        rd_mux[gis_pkg::BIT_PORT_SUM_LO +: 4] = port_irq_summary;
        rd_mux[gis_pkg::BIT_GLOBAL_SUM] = global_summary_flag;
      end
      gis_pkg::OFF_IRQ_SUM_EN: begin
        rd_mux[gis_pkg::BIT_PORT_SUM_LO +: 4] = port_irq_summary_en_q;
        rd_mux[gis_pkg::BIT_GLOBAL_SUM] = global_summary_en_q;
      end
      gis_pkg::OFF_LIVE: begin
        rd_mux[gis_pkg::BIT_UNLOCK_LIVE] = adapter_unlock_live;
        rd_mux[gis_pkg::BIT_UPDATE_LIVE] = global_update_done_live;
      end
      gis_pkg::OFF_LATCHED: begin
        rd_mux[4:0] = latched_q;
      end
      gis_pkg::OFF_LATCHED_EN: begin
        rd_mux[gis_pkg::BIT_ONE_SEC] = one_second_irq_en_q;
        rd_mux[gis_pkg::BIT_UNLOCK_LAT] = adapter_unlock_irq_en_q;
        rd_mux[gis_pkg::BIT_UPDATE_LAT] = update_done_irq_en_q;
      end
      gis_pkg::OFF_PIN_READ: begin
        rd_mux[7:0] = pin_level;
      end
      default: begin
        rd_mux = 16'h0000; // unmapped reads zero
      end
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (rd_en) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign rdata = rdata_q;

endmodule : gis_top

// ---- verif/gis_top_properties.sv ----
// assertions on the pin, read and interrupt ports of the global block
`timescale 1ns/100ps
module gis_top_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rdata,
  input wire logic [3:0] port_irq_pending,
  input wire logic [3:0] port_status_a,
  input wire logic ref8k_out,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic irq_n_out,
  input wire logic irq_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] func_q;
  logic [9:8] ref_q;
  logic idle_q;
  logic [3:0] en_q;
  // shadow of the control fields written by software
  always_ff @(posedge clk) begin
    if (rst) begin
      func_q <= 16'h0000;
      ref_q <= 2'h0;
      idle_q <= 1'b0;
      en_q <= 4'h0;
    end else if (wr_en) begin
      if (addr == gis_pkg::OFF_PIN_FUNC) func_q <= wdata;
      if (addr == gis_pkg::OFF_REF_CTRL) ref_q <= wdata[9:8];
      if (addr == gis_pkg::OFF_CTRL) idle_q <= wdata[14];
      if (addr == gis_pkg::OFF_IRQ_SUM_EN) en_q <= wdata[7:4];
    end
  end
  // an enabled port request seen in one cycle
  sequence s_port_req;
    |(port_irq_pending & en_q);
  endsequence
  // --------------------------------------
  // checks
  // --------------------------------------
  chk_pin_input: assert property (
    $past(func_q[1:0]) == gis_pkg::SEL_INPUT |-> !gpio_oe[0])
    else $error("pin1 driven in input mode");
  chk_pin_low: assert property (
    $past(func_q[1:0]) == gis_pkg::SEL_LOW |-> gpio_oe[0] && !gpio_out[0])
    else $error("pin1 not driven low");
  chk_pin_high: assert property (
    $past(func_q[1:0]) == gis_pkg::SEL_HIGH |-> gpio_oe[0] && gpio_out[0])
    else $error("pin1 not driven high");
  chk_pin_status: assert property (
    $past(func_q[9:8]) == gis_pkg::SEL_STATUS
      |-> gpio_oe[4] && gpio_out[4] == $past(port_status_a[2]))
    else $error("pin5 does not carry port3 status");
  chk_ref_input: assert property (
    $past(ref_q[8]) |-> !gpio_oe[3])
    else $error("pin4 driven while reference input");
  chk_ref_output: assert property (
    $past(ref_q[9]) |-> gpio_oe[1] && gpio_out[1] == $past(ref8k_out))
    else $error("pin2 does not carry reference");
  chk_port_irq: assert property (
    s_port_req [*3] |-> !irq_n_out && irq_n_oe)
    else $error("enabled port request not signalled");
  chk_idle_drive: assert property (
    irq_n_out |-> irq_n_oe == $past(idle_q))
    else $error("idle interrupt pin drive wrong");
  chk_rdata_quiet: assert property (
    !$past(rd_en) |-> rdata == 16'h0000)
    else $error("read data outside read cycle");
  chk_read_pins: assert property (
    $past(rd_en) && $past(addr) == gis_pkg::OFF_PIN_READ
      |-> rdata[15:8] == 8'h00
      && (rdata[7:0] & $past(gpio_oe)) == ($past(gpio_out) & $past(gpio_oe)))
    else $error("pin readback differs from driven level");
endmodule : gis_top_properties

bind gis_top gis_top_properties u_props (.clk, .rst, .addr, .wdata, .wr_en,
  .rd_en, .rdata, .port_irq_pending, .port_status_a, .ref8k_out, .gpio_out,
  .gpio_oe, .irq_n_out, .irq_n_oe);

// ---- verif/gis_top_tb.sv ----
// self-checking bench for the global interrupt, status and pin block
`timescale 1ns/100ps
module gis_top_tb;
  logic clk, rst, wr_en, rd_en, ref8k_out, adapter_clock_pin_a;
  logic global_update_request, ref8k_in, irq_n_out, irq_n_oe;
  logic [9:0] addr;
  logic [15:0] wdata, rdata;
  logic [3:0] port_irq_pending, port_status_a, port_status_b;
  logic [3:0] port_update_done, port_update_source_sel;
  logic [2:0] adapter_pll_locked;
  logic [7:0] gpio_in, gpio_out, gpio_oe;
  int err_count, checks;
  // pin select, expected enables, driven levels, readback
  logic [15:0] rows [5][4] = '{
    '{16'h0000, 16'h0000, 16'h0000, 16'h00a5},
    '{16'h02aa, 16'h001f, 16'h0000, 16'h00a0},
    '{16'h03ff, 16'h001f, 16'h001f, 16'h00bf},
    '{16'h0155, 16'h001f, 16'h001b, 16'h00bb},
    '{16'h004b, 16'h000b, 16'h0009, 16'h00ad}};

  gis_top #(.one_sec_cycles(100), .act_window(16)) DUT (.clk, .rst, .addr,
    .wdata, .wr_en, .rd_en, .rdata, .port_irq_pending, .port_status_a,
    .port_status_b, .port_update_done, .port_update_source_sel,
    .global_update_request, .adapter_pll_locked, .adapter_clock_pin_a,
    .ref8k_out, .ref8k_in, .gpio_in, .gpio_out, .gpio_oe, .irq_n_out,
    .irq_n_oe);

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // read and compare the masked word
  task automatic rc(input logic [9:0] a, input logic [15:0] m,
    input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask : rc

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // bounded wait for the interrupt pin to go active
  task automatic wait_irq();
    repeat (150) begin
      @(posedge clk);
      if (irq_n_out === 1'b0) break;
    end
    #1;
  endtask : wait_irq

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst, wr_en, rd_en, ref8k_out, adapter_clock_pin_a} = 5'b10000;
    addr = 10'h000;
    wdata = 16'h0000;
    {port_irq_pending, port_update_done, port_update_source_sel} = 12'h000;
    port_status_a = 4'h5;
    port_status_b = 4'h3;
    adapter_pll_locked = 3'b111;
    gpio_in = 8'ha5;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rc(gis_pkg::OFF_IRQ_SUM_EN, 16'hffff, 16'h0000);
    rc(gis_pkg::OFF_LATCHED_EN, 16'hffff, 16'h0000);
    chk({14'h0, irq_n_out, irq_n_oe}, 16'h0002);
    foreach (rows[i]) begin
      wr(gis_pkg::OFF_PIN_FUNC, rows[i][0]);
      settle(2);
      chk({8'h00, gpio_oe}, rows[i][1]);
      chk({8'h00, gpio_out & gpio_oe}, rows[i][2]);
      rc(gis_pkg::OFF_PIN_READ, 16'hffff, rows[i][3]);
    end
    // port request masked, then enabled, idle drive modes
    port_irq_pending <= 4'h4;
    rc(gis_pkg::OFF_IRQ_SUM, 16'h00f0, 16'h0040);
    chk({15'h0, irq_n_out}, 16'h0001);
    wr(gis_pkg::OFF_IRQ_SUM_EN, 16'h0040);
    settle(3);
    chk({14'h0, irq_n_out, irq_n_oe}, 16'h0001);
    port_irq_pending <= 4'h0;
    settle(3);
    chk({14'h0, irq_n_out, irq_n_oe}, 16'h0002);
    wr(gis_pkg::OFF_CTRL, 16'h4000);
    settle(3);
    chk({14'h0, irq_n_out, irq_n_oe}, 16'h0003);
    wr(gis_pkg::OFF_IRQ_SUM_EN, 16'h0000);
    // update handshake, port 3 done but not globally selected
    port_update_source_sel <= 4'h3;
    wr(gis_pkg::OFF_CTRL, 16'h0008);
    port_update_done <= 4'h5;
    settle(3);
    chk({15'h0, global_update_request}, 16'h0001);
    rc(gis_pkg::OFF_LIVE, 16'h0001, 16'h0000);
    port_update_done <= 4'h3;
    settle(3);
    rc(gis_pkg::OFF_LIVE, 16'h0001, 16'h0001);
    rc(gis_pkg::OFF_LATCHED, 16'h0001, 16'h0001);
    wr(gis_pkg::OFF_CTRL, 16'h0000);
    // one lock lost
    adapter_pll_locked <= 3'b101;
    settle(8);
    rc(gis_pkg::OFF_LIVE, 16'h0002, 16'h0002);
    rc(gis_pkg::OFF_LATCHED, 16'h0002, 16'h0002);
    adapter_pll_locked <= 3'b111;
    // reference pins and activity
    wr(gis_pkg::OFF_PIN_FUNC, 16'h0088);
    wr(gis_pkg::OFF_REF_CTRL, 16'h0300);
    ref8k_out <= 1'b1;
    settle(3);
    chk({14'h0, gpio_oe[1], gpio_out[1]}, 16'h0003);
    chk({15'h0, gpio_oe[3]}, 16'h0000);
    repeat (7) begin
      gpio_in[3] <= ~gpio_in[3];
      adapter_clock_pin_a <= ~adapter_clock_pin_a;
      settle(6);
    end
    chk({15'h0, ref8k_in}, {15'h0, gpio_in[3]});
    rc(gis_pkg::OFF_LATCHED, 16'h0018, 16'h0018);
    wr(gis_pkg::OFF_REF_CTRL, 16'h0000);
    // one-second tick, clear on write then on read
    wr(gis_pkg::OFF_LATCHED, 16'h001f);
    wr(gis_pkg::OFF_LATCHED_EN, 16'h0004);
    wr(gis_pkg::OFF_IRQ_SUM_EN, 16'h0001);
    wait_irq();
    chk({15'h0, irq_n_out}, 16'h0000);
    rc(gis_pkg::OFF_IRQ_SUM, 16'h0001, 16'h0001);
    rc(gis_pkg::OFF_LATCHED, 16'h0004, 16'h0004);
    wr(gis_pkg::OFF_LATCHED, 16'h0004);
    rc(gis_pkg::OFF_LATCHED, 16'h0004, 16'h0000);
    settle(2);
    chk({15'h0, irq_n_out}, 16'h0001);
    wr(gis_pkg::OFF_CTRL, 16'h0004);
    wait_irq();
    rc(gis_pkg::OFF_LATCHED, 16'h0004, 16'h0004);
    rc(gis_pkg::OFF_LATCHED, 16'h0004, 16'h0000);
    // unmapped and read-only places
    rc(10'h01e, 16'hffff, 16'h0000);
    wr(gis_pkg::OFF_LIVE, 16'hffff);
    rc(gis_pkg::OFF_LIVE, 16'hfffc, 16'h0000);
    // mid-run reset returns pins, enables and latches to idle
    wr(gis_pkg::OFF_IRQ_SUM_EN, 16'h00f1);
    rst <= 1'b1;
    settle(2);
    rst <= 1'b0;
    chk({8'h00, gpio_oe}, 16'h0000);
    rc(gis_pkg::OFF_IRQ_SUM_EN, 16'hffff, 16'h0000);
    settle(8);
    rc(gis_pkg::OFF_LATCHED, 16'h0002, 16'h0000);
    wrap_up();
  end
endmodule : gis_top_tb
